// ### bench/alert_unit_props.sv
`timescale 1ns/100ps
`default_nettype none
module alert_unit_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Watched ports
  input wire logic [alert_pkg::GROUP2_W-1:0] faultAlertPin,
  input wire logic [alert_pkg::ADC_W-1:0] supplyVoltageValue,
  input wire logic supplyVoltageValid,
  input wire logic [alert_pkg::REG_IDX_W-1:0] regIdx,
  input wire logic regRd,
  input wire logic [alert_pkg::REG_DATA_W-1:0] regRdata,
  input wire logic ledDriverOff,
  input wire logic converterOff
);
  import alert_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_LED_OC_OFF: assert property ($rose(faultAlertPin[2]) |-> ##[1:4] ledDriverOff)
    else $error("led driver still on after overcurrent");
  AST_LED_DESAT_OFF: assert property ($rose(faultAlertPin[1]) |-> ##[1:4] ledDriverOff)
    else $error("led driver still on after desaturation");
  AST_CONV_OFF: assert property ($rose(faultAlertPin[0]) |-> ##[1:4] converterOff)
    else $error("converter still on after desaturation");
  AST_RDATA_HOLD: assert property (!regRd |=> $stable(regRdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (regRd && regIdx > 4'hb |=> regRdata == 16'h0000)
    else $error("unmapped index read nonzero");
  AST_ADC_LOW_ZERO: assert property (regRd && regIdx inside {4'ha, 4'hb}
    |=> regRdata[5:0] == 6'h00)
    else $error("result low bits nonzero");
  AST_BYTE_REG_HIGH: assert property (regRd && regIdx <= 4'h9 |=> regRdata[15:8] == 8'h00)
    else $error("byte register upper half nonzero");
  AST_GROUP2_RSV: assert property (regRd && regIdx inside {4'h1, 4'h3, 4'h5, 4'h7, 4'h9}
    |=> regRdata[7:3] == 5'h00)
    else $error("second group reserved bits nonzero");
  AST_VOLT_CAPTURE: assert property (supplyVoltageValid ##1 (regRd && regIdx == 4'ha)
    |=> regRdata[15:6] == $past(supplyVoltageValue, 2))
    else $error("voltage result differs from captured value");
endmodule
bind alert_status_interrupt_unit alert_unit_props props_u (.core_clk(core_clk), .sys_rst(sys_rst),
  .faultAlertPin(faultAlertPin), .supplyVoltageValue(supplyVoltageValue),
  .supplyVoltageValid(supplyVoltageValid), .regIdx(regIdx), .regRd(regRd), .regRdata(regRdata),
  .ledDriverOff(ledDriverOff), .converterOff(converterOff));
`default_nettype wire

// ### bench/mcu_model.sv
`timescale 1ns/100ps
`default_nettype none
module mcu_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output logic [alert_pkg::REG_IDX_W-1:0] regIdx,
  output logic regRd,
  output logic regWr,
  output logic [7:0] regWdata,
  input wire logic [alert_pkg::REG_DATA_W-1:0] regRdata
);
  initial begin
    regIdx = 4'h0;
    regRd = 1'b0;
    regWr = 1'b0;
    regWdata = 8'h00;
  end
  // Idle index and data scrambled so nothing leans on stale values
  task automatic rd(input logic [3:0] i, output logic [15:0] d);
    regIdx = i;
    regRd = 1'b1;
    @(negedge core_clk);
    regRd = 1'b0;
    regIdx = ~i;
    d = regRdata;
    // One idle edge so a following call never re-drives the strobe in this step
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] w);
    regIdx = i;
    regWdata = w;
    regWr = 1'b1;
    @(negedge core_clk);
    regWr = 1'b0;
    regIdx = ~i;
    regWdata = ~w;
    @(negedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import alert_pkg::*;
  typedef struct packed {logic [3:0] idx; logic [7:0] wd; logic [15:0] exp;} row_s;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [GROUP1_W-1:0] g1Pin = '0;
  logic [GROUP2_W-1:0] fPin = '0;
  logic [ADC_W-1:0] vVal = '0, iVal = '0;
  logic vVld = 1'b0, iVld = 1'b0, regRd, regWr, ledOff, convOff, intN;
  logic [3:0] regIdx;
  logic [7:0] regWdata;
  logic [15:0] regRdata;
  int fail_count = 0, compares = 0, cyc = 0;
  row_s rows [9] = '{'{4'h8, 8'hff, 16'h007f}, '{4'h9, 8'hff, 16'h0007}, '{4'h8, 8'h00, 16'h0000},
    '{4'h9, 8'h00, 16'h0000}, '{4'h6, 8'hff, 16'h007f}, '{4'h7, 8'hff, 16'h0007},
    '{4'h1, 8'hff, 16'h0000}, '{4'ha, 8'hff, 16'h0000}, '{4'hf, 8'hff, 16'h0000}};
  always #5 core_clk = ~core_clk;
  alert_status_interrupt_unit dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .group1AlertPin(g1Pin), .faultAlertPin(fPin), .supplyVoltageValue(vVal),
    .supplyVoltageValid(vVld), .supplyCurrentValue(iVal), .supplyCurrentValid(iVld),
    .regIdx(regIdx), .regRd(regRd), .regWr(regWr), .regWdata(regWdata), .regRdata(regRdata),
    .ledDriverOff(ledOff), .converterOff(convOff), .interrupt_line_n(intN));
  mcu_model mcu_u (.core_clk(core_clk), .regIdx(regIdx), .regRd(regRd), .regWr(regWr),
    .regWdata(regWdata), .regRdata(regRdata));
  task end_sim;
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdChk(input logic [3:0] i, input logic [15:0] exp);
    logic [15:0] d;
    mcu_u.rd(i, d);
    chk(d, exp);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) rdChk(4'(i), 16'h0000);
    foreach (rows[k]) begin
      mcu_u.wr(rows[k].idx, rows[k].wd);
      rdChk(rows[k].idx, rows[k].exp);
    end
    for (int i = 0; i < GROUP1_W; i++) begin
      g1Pin[i] = 1'b1;
      repeat (6) @(negedge core_clk);
      chk(16'(intN), 16'h0000);
      rdChk(4'h0, 16'(1 << i));
      g1Pin[i] = 1'b0;
      repeat (6) @(negedge core_clk);
      rdChk(4'h2, 16'(1 << i));
      rdChk(4'h4, 16'(1 << i));
      rdChk(4'h2, 16'h0000);
      repeat (3) @(negedge core_clk);
      chk(16'(intN), 16'h0001);
    end
    for (int j = 0; j < GROUP2_W; j++) begin
      fPin[j] = 1'b1;
      repeat (2) @(negedge core_clk);
      fPin[j] = 1'b0;
      repeat (5) @(negedge core_clk);
      chk(16'(j == 0 ? convOff : ledOff), 16'h0001);
      chk(16'(intN), 16'h0000);
      rdChk(4'h1, 16'h0000);
      rdChk(4'h3, 16'(1 << j));
      rdChk(4'h5, 16'(1 << j));
      repeat (2) @(negedge core_clk);
      chk(16'({convOff, ledOff}), 16'h0000);
    end
    // Rise masked, fall unmasked at the same bit positions
    mcu_u.wr(4'h6, 8'h00);
    mcu_u.wr(4'h7, 8'h00);
    mcu_u.wr(4'h8, 8'h40);
    mcu_u.wr(4'h9, 8'h04);
    g1Pin[6] = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(16'(intN), 16'h0001);
    g1Pin[6] = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(16'(intN), 16'h0000);
    rdChk(4'h4, 16'h0040);
    rdChk(4'h2, 16'h0040);
    repeat (2) @(negedge core_clk);
    chk(16'(intN), 16'h0001);
    fPin[2] = 1'b1;
    repeat (2) @(negedge core_clk);
    fPin[2] = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(16'(intN), 16'h0000);
    rdChk(4'h5, 16'h0004);
    rdChk(4'h3, 16'h0004);
    repeat (2) @(negedge core_clk);
    chk(16'({intN, ledOff}), 16'h0002);
    vVal = 10'h2a5;
    iVal = 10'h15a;
    vVld = 1'b1;
    iVld = 1'b1;
    @(negedge core_clk);
    vVld = 1'b0;
    iVld = 1'b0;
    rdChk(4'ha, {10'h2a5, 6'h00});
    rdChk(4'hb, {10'h15a, 6'h00});
    sys_rst = 1'b1;
    @(negedge core_clk);
    sys_rst = 1'b0;
    rdChk(4'h6, 16'h0000);
    end_sim();
  end
endmodule
`default_nettype wire

// ### src/alert_pkg.sv
// Behaviour
// - Rising alert sets its positive-event flag, held until that flag register is read.
// - Falling alert sets its negative-event flag, held until that flag register is read.
// - Alert and event bits read 1 for active, 0 for inactive.
// - LED overcurrent alert is the comparator output for scaled LED current above 3.
// - LED overcurrent turns the LED driver off; the positive-event flag keeps the occurrence.
// - LED desaturation turns the LED driver off and latches its positive-event flag.
// - Converter desaturation turns the converter off and latches its positive-event flag.
// - Second group: LED overcurrent bit 2, LED desaturation bit 1, converter bit 0.
// - Second-group status bits 3 to 7 read as zero.
// - First-group rise enable: seven writable bits, 1 unmasks; bit 7 read-only.
// - Second-group rise enable: three writable bits unmasking the three faults.
// - First-group fall enable masks the seven alerts, same positions as rise enable.
// - Second-group fall enable masks the three faults, same positions as rise enable.
// - Supply voltage result: 10-bit value in bits 6 to 15, low six bits zero.
// - Supply current result: 10-bit value in bits 6 to 15, low six bits zero.
package alert_pkg;
  localparam int GROUP1_W = 7;
  localparam int GROUP2_W = 3;
  localparam int ADC_W = 10;
  localparam int ADC_LSB = 6;
  localparam int REG_DATA_W = 16;
  localparam int REG_IDX_W = 4;

  // First-group bit positions
  localparam int BIT_FIRST_RAIL_OC = 0;
  localparam int BIT_SECOND_RAIL_OC = 1;
  localparam int BIT_LED_UNDERVOLTAGE = 2;
  localparam int BIT_LED_OVERVOLTAGE = 3;
  localparam int BIT_LED_THERMAL_WARNING = 4;
  localparam int BIT_LED_THERMAL_SHUTDOWN = 5;
  localparam int BIT_CHIP_THERMAL_WARNING = 6;
  // Second-group bit positions
  localparam int BIT_CONVERTER_DESAT = 0;
  localparam int BIT_LED_DESAT = 1;
  localparam int BIT_LED_OVERCURRENT = 2;

  // Register indices
  localparam logic [REG_IDX_W-1:0] IDX_GROUP1_LIVE = 4'h0;
  localparam logic [REG_IDX_W-1:0] IDX_FAULT_LIVE = 4'h1;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP1_RISE = 4'h2;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP2_RISE = 4'h3;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP1_FALL = 4'h4;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP2_FALL = 4'h5;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP1_RISE_EN = 4'h6;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP2_RISE_EN = 4'h7;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP1_FALL_EN = 4'h8;
  localparam logic [REG_IDX_W-1:0] IDX_GROUP2_FALL_EN = 4'h9;
  localparam logic [REG_IDX_W-1:0] IDX_SUPPLY_VOLTAGE = 4'ha;
  localparam logic [REG_IDX_W-1:0] IDX_SUPPLY_CURRENT = 4'hb;

  // Reset values
  localparam logic [GROUP1_W-1:0] RST_GROUP1 = 7'h00;
  localparam logic [GROUP2_W-1:0] RST_GROUP2 = 3'h0;
  localparam logic [ADC_W-1:0] RST_ADC = 10'h000;
  localparam logic [REG_DATA_W-1:0] RST_RDATA = 16'h0000;
endpackage

// ### src/alert_status_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
module alert_status_interrupt_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Comparator alerts, asynchronous to core_clk
  input wire logic [alert_pkg::GROUP1_W-1:0] group1AlertPin,
  input wire logic [alert_pkg::GROUP2_W-1:0] faultAlertPin,
  // Converter results, same clock
  input wire logic [alert_pkg::ADC_W-1:0] supplyVoltageValue,
  input wire logic supplyVoltageValid,
  input wire logic [alert_pkg::ADC_W-1:0] supplyCurrentValue,
  input wire logic supplyCurrentValid,
  // Register port from the serial interface
  input wire logic [alert_pkg::REG_IDX_W-1:0] regIdx,
  input wire logic regRd,
  input wire logic regWr,
  input wire logic [7:0] regWdata,
  output logic [alert_pkg::REG_DATA_W-1:0] regRdata,
  // Power stage and interrupt
  output logic ledDriverOff,
  output logic converterOff,
  output logic interrupt_line_n
);
  import alert_pkg::*;

  typedef struct packed {
    logic [GROUP1_W-1:0] group1RiseEn;
    logic [GROUP2_W-1:0] group2RiseEn;
    logic [GROUP1_W-1:0] group1FallEn;
    logic [GROUP2_W-1:0] group2FallEn;
    logic [ADC_W-1:0] supplyVoltage;
    logic [ADC_W-1:0] supplyCurrent;
    logic [REG_DATA_W-1:0] rdata;
    logic ledOff;
    logic convOff;
    logic intN;
  } unit_s;

  unit_s state_r;
  unit_s state_nxt;

  event_if #(.W(GROUP1_W)) group1Ev ();
  event_if #(.W(GROUP2_W)) group2Ev ();

  // Comparator outputs arrive here; the scaled LED current test comes in on faultAlertPin bit 2
  edge_event_latch #(.W(GROUP1_W)) group1Latch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .alertPin(group1AlertPin),
    .ev(group1Ev.latch)
  );

  edge_event_latch #(.W(GROUP2_W)) group2Latch (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .alertPin(faultAlertPin),
    .ev(group2Ev.latch)
  );

  function automatic logic [REG_DATA_W-1:0] byteField(input logic [GROUP1_W-1:0] bits);
    byteField = {9'h000, bits};
  endfunction

  function automatic logic [REG_DATA_W-1:0] adcField(input logic [ADC_W-1:0] value);
    adcField = {value, 6'h00};
  endfunction

  logic rdHit;
  logic [REG_DATA_W-1:0] readMux;
  logic anyEnabled;
  logic ledFault;

  assign rdHit = regRd;
  assign group1Ev.clrRise = rdHit && (regIdx == IDX_GROUP1_RISE);
  assign group2Ev.clrRise = rdHit && (regIdx == IDX_GROUP2_RISE);
  assign group1Ev.clrFall = rdHit && (regIdx == IDX_GROUP1_FALL);
  assign group2Ev.clrFall = rdHit && (regIdx == IDX_GROUP2_FALL);

  always_comb begin
    readMux = '0;
    unique case (regIdx)
      IDX_GROUP1_LIVE: readMux = byteField(group1Ev.live);
      IDX_FAULT_LIVE: readMux = byteField({4'h0, group2Ev.live});
      IDX_GROUP1_RISE: readMux = byteField(group1Ev.rise);
      IDX_GROUP2_RISE: readMux = byteField({4'h0, group2Ev.rise});
      IDX_GROUP1_FALL: readMux = byteField(group1Ev.fall);
      IDX_GROUP2_FALL: readMux = byteField({4'h0, group2Ev.fall});
      IDX_GROUP1_RISE_EN: readMux = byteField(state_r.group1RiseEn);
      IDX_GROUP2_RISE_EN: readMux = byteField({4'h0, state_r.group2RiseEn});
      IDX_GROUP1_FALL_EN: readMux = byteField(state_r.group1FallEn);
      IDX_GROUP2_FALL_EN: readMux = byteField({4'h0, state_r.group2FallEn});
      IDX_SUPPLY_VOLTAGE: readMux = adcField(state_r.supplyVoltage);
      IDX_SUPPLY_CURRENT: readMux = adcField(state_r.supplyCurrent);
      default: readMux = '0;
    endcase
  end

  always_comb begin
    anyEnabled = |(group1Ev.rise & state_r.group1RiseEn)
      | |(group2Ev.rise & state_r.group2RiseEn)
      | |(group1Ev.fall & state_r.group1FallEn)
      | |(group2Ev.fall & state_r.group2FallEn);
    ledFault = group2Ev.live[BIT_LED_OVERCURRENT] | group2Ev.live[BIT_LED_DESAT];
  end

  always_comb begin
    state_nxt = state_r;
    if (regRd) begin
      state_nxt.rdata = readMux;
    end
    if (regWr) begin
      unique case (regIdx)
        IDX_GROUP1_RISE_EN: state_nxt.group1RiseEn = regWdata[GROUP1_W-1:0];
        IDX_GROUP2_RISE_EN: state_nxt.group2RiseEn = regWdata[GROUP2_W-1:0];
        IDX_GROUP1_FALL_EN: state_nxt.group1FallEn = regWdata[GROUP1_W-1:0];
        IDX_GROUP2_FALL_EN: state_nxt.group2FallEn = regWdata[GROUP2_W-1:0];
        default: state_nxt.group1RiseEn = state_r.group1RiseEn;
      endcase
    end
    if (supplyVoltageValid) begin
      state_nxt.supplyVoltage = supplyVoltageValue;
    end
    if (supplyCurrentValid) begin
      state_nxt.supplyCurrent = supplyCurrentValue;
    end
    // Shutdown stays until software has seen the event and the fault is gone
    if (ledFault) begin
      state_nxt.ledOff = 1'b1;
    end else if (group2Ev.clrRise) begin
      state_nxt.ledOff = 1'b0;
    end
    if (group2Ev.live[BIT_CONVERTER_DESAT]) begin
      state_nxt.convOff = 1'b1;
    end else if (group2Ev.clrRise) begin
      state_nxt.convOff = 1'b0;
    end
    state_nxt.intN = ~anyEnabled;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r.group1RiseEn <= RST_GROUP1;
      state_r.group2RiseEn <= RST_GROUP2;
      state_r.group1FallEn <= RST_GROUP1;
      state_r.group2FallEn <= RST_GROUP2;
      state_r.supplyVoltage <= RST_ADC;
      state_r.supplyCurrent <= RST_ADC;
      state_r.rdata <= RST_RDATA;
      state_r.ledOff <= 1'b0;
      state_r.convOff <= 1'b0;
      state_r.intN <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign regRdata = state_r.rdata;
  assign ledDriverOff = state_r.ledOff;
  assign converterOff = state_r.convOff;
  assign interrupt_line_n = state_r.intN;
endmodule
`default_nettype wire

// ### src/edge_event_latch.sv
`timescale 1ns/100ps
`default_nettype none
module edge_event_latch #(
  parameter int W = 7
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Comparator pins, asynchronous
  input wire logic [W-1:0] alertPin,
  // Event side
  event_if.latch ev
);
  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } latch_s;

  latch_s state_r;
  latch_s state_nxt;

  always_comb begin
    state_nxt = state_r;
    state_nxt.sync1 = alertPin;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.prev = state_r.sync2;
    // Set beats a read-clear in the same cycle
    state_nxt.rise = (ev.clrRise ? '0 : state_r.rise) | (state_r.sync2 & ~state_r.prev);
    state_nxt.fall = (ev.clrFall ? '0 : state_r.fall) | (~state_r.sync2 & state_r.prev);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign ev.live = state_r.sync2;
  assign ev.rise = state_r.rise;
  assign ev.fall = state_r.fall;
endmodule
`default_nettype wire

// ### src/event_if.sv
`timescale 1ns/100ps
`default_nettype none
interface event_if #(parameter int W = 7);
  logic [W-1:0] live;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  logic clrRise;
  logic clrFall;
  modport latch (output live, output rise, output fall, input clrRise, input clrFall);
  modport host (input live, input rise, input fall, output clrRise, output clrFall);
endinterface
`default_nettype wire
